// ### core/csb_pkg.sv
// ****************************************************************
// Shared constants of the compare, skip and branch unit.
// ****************************************************************
package csb_pkg;

    // ************************************************************
    // Opcode patterns: a word matches when (word & mask) == value.
    // ************************************************************
    localparam logic [15:0] OPM_CMP_REG = 16'hFC00;
    localparam logic [15:0] OPV_CMP_REG = 16'h1400;
    localparam logic [15:0] OPV_CMP_CARRY = 16'h0400;
    localparam logic [15:0] OPM_CMP_IMM = 16'hF000;
    localparam logic [15:0] OPV_CMP_IMM = 16'h3000;
    localparam logic [15:0] OPM_SKIP_REG = 16'hFE08;
    localparam logic [15:0] OPV_SKIP_REG_ZERO = 16'hFC00;
    localparam logic [15:0] OPV_SKIP_REG_ONE = 16'hFE00;
    localparam logic [15:0] OPM_SKIP_IO = 16'hFF00;
    localparam logic [15:0] OPV_SKIP_IO_ZERO = 16'h9900;
    localparam logic [15:0] OPV_SKIP_IO_ONE = 16'h9B00;
    localparam logic [15:0] OPM_BRANCH = 16'hFC00;
    localparam logic [15:0] OPV_BRANCH_ONE = 16'hF000;
    localparam logic [15:0] OPV_BRANCH_ZERO = 16'hF400;

    // ************************************************************
    // Field positions in the instruction word.
    // ************************************************************
    localparam int BIT_SEL_LSB = 0;
    localparam int IO_ADDR_LSB = 3;
    localparam int BR_OFS_LSB = 3;
    localparam int BR_OFS_W = 7;
    localparam logic [0:0] IMM_REG_HIGH = 1'h1;

    // ************************************************************
    // Flag register bit positions and reset value.
    // ************************************************************
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_H = 5;
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam logic [2:0] BIT_EQUAL = 3'h1;

    // ************************************************************
    // Program counter steps and cycle counts.
    // ************************************************************
    localparam int ADV_SEQ = 1;
    localparam int ADV_SKIP_SHORT = 2;
    localparam int ADV_SKIP_LONG = 3;
    localparam int ADV_BRANCH = 1;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_SKIP_SHORT = 2'h2;
    localparam logic [1:0] CYC_SKIP_LONG = 2'h3;
    localparam logic [1:0] CYC_BR_TAKEN = 2'h2;

    function automatic logic opMatch(input logic [15:0] word, input logic [15:0] mask,
                                     input logic [15:0] value);
        opMatch = ((word & mask) == value);
    endfunction

endpackage

// ### core/csb_sub_flags.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Subtractor that only produces flags; the difference is dropped.
// ****************************************************************
module csb_sub_flags (
    // Operands
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    input wire logic borrowIn,
    // Flags
    output logic zeroF,
    output logic negF,
    output logic ovfF,
    output logic carryF,
    output logic halfF
);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] diff;

    assign full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
    assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrowIn};
    assign diff = full[7:0];
    assign zeroF = (diff == 8'h00);
    assign negF = diff[7];
    assign carryF = full[8];
    assign halfF = low[4];
    assign ovfF = (minuend[7] & ~subtrahend[7] & ~diff[7]) | (~minuend[7] & subtrahend[7] & diff[7]);
endmodule
`default_nettype wire

// ### core/csb_unit.sv
// Design decisions made here: the valid/ready issue port and the address map.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RQ1] Register compare sets flags only, one cycle.
// [RQ2] Compare with carry subtracts carry, one cycle.
// [RQ3] Immediate compare uses constant, one cycle.
// [RQ4] Compares update zero, negative, overflow, carry, half.
// [RQ5] Skip when register bit is zero.
// [RQ6] Skip when register bit is one.
// [RQ7] Skip when I/O bit is zero.
// [RQ8] Skip when I/O bit is one.
// [RQ9] Branch relative when selected flag is one.
// [RQ10] Branch relative when selected flag is zero.
// [RQ11] Branch on equal follows the zero flag.
// [RQ12] Skips and branches never touch flags.
// [RQ13] Skip adds two or three, same cycles.
// [RQ14] Branch offset is signed word displacement.
module csb_unit #(
    parameter int PC_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Instruction issue
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic nextTwoWords,
    output logic instrReady,
    output logic instrDone,
    // Register file read ports
    output logic [4:0] rdAddr,
    output logic [4:0] rrAddr,
    input wire logic [7:0] rdData,
    input wire logic [7:0] rrData,
    // I/O bit read
    output logic [4:0] ioAddr,
    input wire logic [7:0] ioData,
    // Program counter
    input wire logic [PC_W-1:0] pcIn,
    output logic pcLoad,
    output logic [PC_W-1:0] pcNew,
    // Flag register
    input wire logic [7:0] flagIn,
    output logic flagWe,
    output logic [7:0] flagOut
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_STALL = 2'b10
    } csb_state_e;

    csb_state_e state_r;
    csb_state_e state_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cycNxt;
    logic done_r;
    logic pcLoad_r;
    logic [PC_W-1:0] pcNew_r;
    logic [PC_W-1:0] pcNxt;
    logic flagWe_r;
    logic [7:0] flagOut_r;
    logic [7:0] flagNxt;
    logic issue;
    logic isCmpReg, isCmpCarry, isCmpImm, isCmp;
    logic isSkipRegZero, isSkipRegOne, isSkipIoZero, isSkipIoOne, isSkip;
    logic isBrOne, isBrZero, isBr, known;
    logic [2:0] bitSel;
    logic testBit, skipTaken, brTaken;
    logic [7:0] subB;
    logic [7:0] immK;
    logic subCin;
    logic fZ, fN, fV, fC, fH;
    logic [PC_W-1:0] brOfs;

    // ************************************************************
    // Decode.
    // ************************************************************
    assign isCmpReg = csb_pkg::opMatch(instrWord, csb_pkg::OPM_CMP_REG, csb_pkg::OPV_CMP_REG);
    assign isCmpCarry = csb_pkg::opMatch(instrWord, csb_pkg::OPM_CMP_REG, csb_pkg::OPV_CMP_CARRY);
    assign isCmpImm = csb_pkg::opMatch(instrWord, csb_pkg::OPM_CMP_IMM, csb_pkg::OPV_CMP_IMM);
    assign isSkipRegZero = csb_pkg::opMatch(instrWord, csb_pkg::OPM_SKIP_REG, csb_pkg::OPV_SKIP_REG_ZERO);
    assign isSkipRegOne = csb_pkg::opMatch(instrWord, csb_pkg::OPM_SKIP_REG, csb_pkg::OPV_SKIP_REG_ONE);
    assign isSkipIoZero = csb_pkg::opMatch(instrWord, csb_pkg::OPM_SKIP_IO, csb_pkg::OPV_SKIP_IO_ZERO);
    assign isSkipIoOne = csb_pkg::opMatch(instrWord, csb_pkg::OPM_SKIP_IO, csb_pkg::OPV_SKIP_IO_ONE);
    assign isBrOne = csb_pkg::opMatch(instrWord, csb_pkg::OPM_BRANCH, csb_pkg::OPV_BRANCH_ONE);
    assign isBrZero = csb_pkg::opMatch(instrWord, csb_pkg::OPM_BRANCH, csb_pkg::OPV_BRANCH_ZERO);
    assign isCmp = isCmpReg | isCmpCarry | isCmpImm;
    assign isSkip = isSkipRegZero | isSkipRegOne | isSkipIoZero | isSkipIoOne;
    assign isBr = isBrOne | isBrZero;
    assign known = isCmp | isSkip | isBr;
    assign instrReady = (state_r == ST_IDLE);
    assign issue = instrValid & instrReady;

    // Immediate compares can only name the upper half of the register file.
    assign rdAddr = isCmpImm ? {csb_pkg::IMM_REG_HIGH, instrWord[7:4]} : instrWord[8:4];
    assign rrAddr = {instrWord[9], instrWord[3:0]};
    assign ioAddr = instrWord[csb_pkg::IO_ADDR_LSB +: 5];
    assign bitSel = instrWord[csb_pkg::BIT_SEL_LSB +: 3];
    assign immK = {instrWord[11:8], instrWord[3:0]};

    // ************************************************************
    // Compare: flags from a subtraction whose result is dropped.
    // ************************************************************
    assign subB = isCmpImm ? immK : rrData; // RQ3
    assign subCin = isCmpCarry & flagIn[csb_pkg::FLG_C]; // RQ2

    csb_sub_flags u_sub (
        .minuend(rdData),
        .subtrahend(subB),
        .borrowIn(subCin),
        .zeroF(fZ),
        .negF(fN),
        .ovfF(fV),
        .carryF(fC),
        .halfF(fH)
    );

    always_comb begin
        flagNxt = flagIn;
        flagNxt[csb_pkg::FLG_Z] = fZ; // RQ4
        flagNxt[csb_pkg::FLG_N] = fN; // RQ4
        flagNxt[csb_pkg::FLG_V] = fV; // RQ4
        flagNxt[csb_pkg::FLG_C] = fC; // RQ4
        flagNxt[csb_pkg::FLG_H] = fH; // RQ4
    end

    // ************************************************************
    // Skip and branch decisions.
    // ************************************************************
    assign testBit = (isSkipIoZero | isSkipIoOne) ? ioData[bitSel] : rdData[bitSel];
    assign skipTaken = ((isSkipRegZero & ~testBit) // RQ5
                     | (isSkipIoZero & ~testBit) // RQ7
                     | (isSkipRegOne & testBit) // RQ6
                     | (isSkipIoOne & testBit)); // RQ8
    assign brTaken = (isBrOne & flagIn[bitSel]) // RQ9 RQ11
                   | (isBrZero & ~flagIn[bitSel]); // RQ10
    assign brOfs = {{(PC_W - csb_pkg::BR_OFS_W){instrWord[9]}}, instrWord[csb_pkg::BR_OFS_LSB +: 7]}; // RQ14

    always_comb begin
        pcNxt = pcIn + PC_W'(csb_pkg::ADV_SEQ);
        cycNxt = csb_pkg::CYC_ONE; // RQ1 RQ2 RQ3
        if (skipTaken) begin
            if (nextTwoWords) begin
                pcNxt = pcIn + PC_W'(csb_pkg::ADV_SKIP_LONG); // RQ13
                cycNxt = csb_pkg::CYC_SKIP_LONG; // RQ13
            end else begin
                pcNxt = pcIn + PC_W'(csb_pkg::ADV_SKIP_SHORT); // RQ13
                cycNxt = csb_pkg::CYC_SKIP_SHORT; // RQ13
            end
        end else if (brTaken) begin
            pcNxt = pcIn + brOfs + PC_W'(csb_pkg::ADV_BRANCH); // RQ9 RQ10 RQ11
            cycNxt = csb_pkg::CYC_BR_TAKEN; // RQ9 RQ10
        end
    end

    // ************************************************************
    // Sequencing. Extra cycles of a taken skip or branch stall issue,
    // which stands in for the flushed fetch of the skipped word.
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (issue && known && (cycNxt != csb_pkg::CYC_ONE)) begin
                    state_nxt = ST_STALL;
                end
            end
            ST_STALL: begin
                if (cnt_r == csb_pkg::CYC_ONE) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            if (issue && known) begin
                cnt_r <= cycNxt - csb_pkg::CYC_ONE;
            end else if (state_r == ST_STALL) begin
                cnt_r <= cnt_r - csb_pkg::CYC_ONE;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (issue && known && (cycNxt == csb_pkg::CYC_ONE))
                   || ((state_r == ST_STALL) && (cnt_r == csb_pkg::CYC_ONE));
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pcLoad_r <= 1'b0;
            pcNew_r <= '0;
        end else begin
            pcLoad_r <= issue && known;
            if (issue && known) begin
                pcNew_r <= pcNxt;
            end
        end
    end

    // Only compares write flags; the register file is never written.
    always_ff @(posedge mclk) begin
        if (rst) begin
            flagWe_r <= 1'b0;
            flagOut_r <= csb_pkg::FLAG_RST;
        end else begin
            flagWe_r <= issue && isCmp; // RQ1 RQ12
            if (issue && isCmp) begin
                flagOut_r <= flagNxt;
            end
        end
    end

    assign instrDone = done_r;
    assign pcLoad = pcLoad_r;
    assign pcNew = pcNew_r;
    assign flagWe = flagWe_r;
    assign flagOut = flagOut_r;

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic [8:0] refDiff;
    logic [PC_W-1:0] refTarget;
    assign refDiff = {1'b0, rdData} - {1'b0, subB} - {8'h00, subCin};
    assign refTarget = pcIn + PC_W'(signed'(instrWord[9:3])) + PC_W'(1);

    AST_CMP_ONE_CYCLE: assert property (issue && isCmp |=> instrDone && flagWe && instrReady) // RQ1
        else $error("compare did not finish in one cycle");
    AST_CMP_ZERO: assert property (issue && isCmp |=> flagOut[csb_pkg::FLG_Z] == ($past(refDiff[7:0]) == 8'h00)) // RQ4
        else $error("compare zero flag wrong");
    AST_CMP_CARRY: assert property (issue && isCmpCarry |=> flagOut[csb_pkg::FLG_C] == $past(refDiff[8])) // RQ2
        else $error("compare with carry borrow wrong");
    AST_CMP_IMM_NEG: assert property (issue && isCmpImm |=> flagOut[csb_pkg::FLG_N] == $past(refDiff[7])) // RQ3
        else $error("immediate compare negative flag wrong");
    // A compare may follow an untaken skip at once, so its own write is allowed in the second cycle.
    AST_NO_FLAGS: assert property (issue && (isSkip || isBr)
        |=> !flagWe ##1 (!flagWe || $past(issue && isCmp))) // RQ12
        else $error("skip or branch wrote flags");
    AST_SKIP_SHORT: assert property (issue && skipTaken && !nextTwoWords
        |=> pcLoad && pcNew == $past(pcIn) + PC_W'(2) && !instrReady ##1 instrDone) // RQ5
        else $error("short skip wrong");
    AST_SKIP_LONG: assert property (issue && skipTaken && nextTwoWords
        |=> (pcNew == $past(pcIn) + PC_W'(3)) ##0 (!instrReady)[*2] ##1 (instrReady && instrDone)) // RQ13
        else $error("long skip wrong");
    AST_SKIP_NOT: assert property (issue && isSkip && !skipTaken |=> instrDone && pcNew == $past(pcIn) + PC_W'(1)) // RQ7
        else $error("untaken skip wrong");
    AST_BR_TAKEN: assert property (issue && brTaken |=> pcNew == $past(refTarget) ##1 instrDone) // RQ14
        else $error("taken branch target wrong");
    AST_BR_EQUAL: assert property (issue && isBrOne && bitSel == csb_pkg::BIT_EQUAL
        && !flagIn[csb_pkg::FLG_Z] |=> instrDone && pcNew == $past(pcIn) + PC_W'(1)) // RQ11
        else $error("equal branch fell through wrong");

    COV_CMP: cover property (issue && isCmpCarry);
    COV_SKIP_LONG: cover property (issue && skipTaken && nextTwoWords);
    COV_BR_BACK: cover property (issue && brTaken && instrWord[9]);
    COV_BACK_TO_BACK: cover property (issue && isCmp ##1 issue && isBr);
endmodule
`default_nettype wire

// ### testbench/csb_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module csb_unit_tb_top;
    localparam int PC_W = 16;
    localparam logic [15:0] OP_MASK [0:9] = '{csb_pkg::OPM_CMP_REG, csb_pkg::OPM_CMP_REG, csb_pkg::OPM_CMP_IMM,
        csb_pkg::OPM_SKIP_REG, csb_pkg::OPM_SKIP_REG, csb_pkg::OPM_SKIP_IO, csb_pkg::OPM_SKIP_IO,
        csb_pkg::OPM_BRANCH, csb_pkg::OPM_BRANCH, 16'hFFFF};
    localparam logic [15:0] OP_VAL [0:9] = '{csb_pkg::OPV_CMP_REG, csb_pkg::OPV_CMP_CARRY, csb_pkg::OPV_CMP_IMM,
        csb_pkg::OPV_SKIP_REG_ZERO, csb_pkg::OPV_SKIP_REG_ONE, csb_pkg::OPV_SKIP_IO_ZERO, csb_pkg::OPV_SKIP_IO_ONE,
        csb_pkg::OPV_BRANCH_ONE, csb_pkg::OPV_BRANCH_ZERO, 16'h0000};
    logic mclk, rst, rstSeen, instrValid, nextTwoWords, instrReady, instrDone, pcLoad, flagWe, expCmp;
    logic [15:0] instrWord;
    logic [4:0] rdAddr, rrAddr, ioAddr;
    logic [7:0] rdData, rrData, ioData, flagIn, flagOut, expFlags, r8;
    logic [PC_W-1:0] pcIn, pcNew, expPc, rw;
    logic [31:0] seed;
    int badCount, comparisons, age, expN, k;

    csb_unit #(.PC_W(PC_W)) dut (.mclk(mclk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
        .nextTwoWords(nextTwoWords), .instrReady(instrReady), .instrDone(instrDone), .rdAddr(rdAddr),
        .rrAddr(rrAddr), .rdData(rdData), .rrData(rrData), .ioAddr(ioAddr), .ioData(ioData), .pcIn(pcIn),
        .pcLoad(pcLoad), .pcNew(pcNew), .flagIn(flagIn), .flagWe(flagWe), .flagOut(flagOut));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Reset as the design saw it at the last edge, so checks do not lead the design by a cycle.
    always @(posedge mclk) rstSeen <= rst;

    function logic [7:0] rb();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rb = seed[7:0];
    endfunction

    task check(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            badCount++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask

    function automatic logic [7:0] cmpFlags(input logic [7:0] f, d, s, input logic c);
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] r;
        full = {1'b0, d} - {1'b0, s} - {8'h00, c};
        low = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, c};
        r = full[7:0];
        f[csb_pkg::FLG_C] = full[8];
        f[csb_pkg::FLG_Z] = (r == 8'h00);
        f[csb_pkg::FLG_N] = r[7];
        f[csb_pkg::FLG_V] = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
        f[csb_pkg::FLG_H] = low[4];
        cmpFlags = f;
    endfunction

    task automatic predict(input logic [15:0] w, input logic ntw, input logic [7:0] d, s, io, f,
                           input logic [PC_W-1:0] pc);
        logic hit;
        hit = 1'b0;
        expN = 1;
        expCmp = 1'b0;
        expPc = pc + 16'h0001;
        if ((w & csb_pkg::OPM_CMP_REG) == csb_pkg::OPV_CMP_REG) begin
            expCmp = 1'b1;
            expFlags = cmpFlags(f, d, s, 1'b0);
        end else if ((w & csb_pkg::OPM_CMP_REG) == csb_pkg::OPV_CMP_CARRY) begin
            expCmp = 1'b1;
            expFlags = cmpFlags(f, d, s, f[csb_pkg::FLG_C]);
        end else if ((w & csb_pkg::OPM_CMP_IMM) == csb_pkg::OPV_CMP_IMM) begin
            expCmp = 1'b1;
            expFlags = cmpFlags(f, d, {w[11:8], w[3:0]}, 1'b0);
        end else if ((w & csb_pkg::OPM_SKIP_REG) == csb_pkg::OPV_SKIP_REG_ZERO
                     || (w & csb_pkg::OPM_SKIP_REG) == csb_pkg::OPV_SKIP_REG_ONE) begin
            hit = (d[w[2:0]] == w[9]);
        end else if ((w & csb_pkg::OPM_SKIP_IO) == csb_pkg::OPV_SKIP_IO_ZERO
                     || (w & csb_pkg::OPM_SKIP_IO) == csb_pkg::OPV_SKIP_IO_ONE) begin
            hit = (io[w[2:0]] == w[9]);
        end else if ((w & csb_pkg::OPM_BRANCH) == csb_pkg::OPV_BRANCH_ONE
                     || (w & csb_pkg::OPM_BRANCH) == csb_pkg::OPV_BRANCH_ZERO) begin
            if (f[w[2:0]] == !w[10]) begin
                expN = 2;
                expPc = pc + {{9{w[9]}}, w[9:3]} + 16'h0001;
            end
        end else begin
            expN = 0;
        end
        if (hit) begin
            expN = ntw ? 3 : 2;
            expPc = pc + (ntw ? 16'h0003 : 16'h0002);
        end
    endtask

    // The word stays offered while the unit is busy, so every wait cycle is also a refused request.
    task automatic issue(input logic [15:0] w, input logic ntw, input logic [7:0] d, s, io, f);
        logic [PC_W-1:0] pc;
        pc = {rb(), rb()};
        instrValid <= 1'b1;
        instrWord <= w;
        nextTwoWords <= ntw;
        rdData <= d;
        rrData <= s;
        ioData <= io;
        flagIn <= f;
        pcIn <= pc;
        #10;
        check(ioAddr === w[7:3] && rrAddr === {w[9], w[3:0]}, "operand index");
        check(rdAddr === (((w & csb_pkg::OPM_CMP_IMM) == csb_pkg::OPV_CMP_IMM) ? {1'b1, w[7:4]} : w[8:4]),
              "register index");
        @(posedge mclk);
        predict(w, ntw, d, s, io, f, pc);
        if (expN != 0) age = 1;
        if (expN > 1) repeat (expN - 1) @(posedge mclk);
    endtask

    always @(negedge mclk) begin
        if (rstSeen) begin
            check(instrReady === 1'b1 && instrDone === 1'b0 && pcLoad === 1'b0 && flagWe === 1'b0
                  && pcNew === 16'h0000 && flagOut === 8'h00, "reset values");
            age = 0;
        end else if (age == 0) begin
            check(pcLoad === 1'b0 && flagWe === 1'b0 && instrDone === 1'b0 && instrReady === 1'b1, "idle");
        end else begin
            if (age == 1) begin
                check(pcLoad === 1'b1 && pcNew === expPc, "new pc");
                check(flagWe === expCmp, "flag write");
                if (expCmp) check(flagOut === expFlags, "flags");
            end else begin
                check(pcLoad === 1'b0 && flagWe === 1'b0, "extra pulse");
            end
            check(instrDone === (age == expN) && instrReady === (age == expN), "cycles");
            age = (age == expN) ? 0 : age + 1;
        end
    end

    task finalReport();
        $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8000) @(posedge mclk);
        badCount++;
        finalReport();
    end

    task automatic randomRun(input int count);
        for (int i = 0; i < count; i++) begin
            k = rb() % 10;
            rw = {rb(), rb()};
            r8 = rb();
            issue((rw & ~OP_MASK[k]) | OP_VAL[k], r8[0], rb(), rb(), rb(), rb());
        end
    endtask

    initial begin
        seed = 32'hF0930A84;
        {badCount, comparisons, age, expN, k} = '0;
        {expCmp, expFlags, expPc, rw, r8} = '0;
        {rst, rstSeen} = 2'h3;
        {instrValid, nextTwoWords, instrWord, rdData, rrData, ioData, flagIn, pcIn} = '0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        issue(csb_pkg::OPV_CMP_REG | 16'h0012, 1'b0, 8'h5A, 8'h5A, 8'h00, 8'hFF);
        issue(csb_pkg::OPV_CMP_CARRY, 1'b0, 8'h10, 8'h10, 8'h00, 8'h01);
        issue(csb_pkg::OPV_CMP_IMM | 16'h0F0F, 1'b0, 8'h80, 8'h00, 8'h00, 8'h00);
        for (int j = 3; j < 9; j++) begin
            for (int t = 0; t < 4; t++) begin
                issue(OP_VAL[j] | 16'h0005, t[1], {8{t[0]}}, 8'h00, {8{t[0]}}, {8{t[0]}});
            end
        end
        issue(16'hF201, 1'b0, 8'h00, 8'h00, 8'h00, 8'h02);
        issue(16'hF201, 1'b0, 8'h00, 8'h00, 8'h00, 8'hFD);
        issue(16'hF5F9, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00);
        issue(16'h0000, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00);
        randomRun(300);
        instrValid <= 1'b0;
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        randomRun(40);
        finalReport();
    end
endmodule
`default_nettype wire
